// >>> logic/stc_defs.svh
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
// register byte addresses on the avalon bus
`define STC_ADDR_COUNT_LOW 4'h0
`define STC_ADDR_COUNT_HIGH 4'h4
`define STC_ADDR_CONTROL 4'h8
`define STC_ADDR_STATUS 4'hc
// interrupt write-one clear and enable, then port view and oscillator mode
`define STC_ADDR_IRQ_CLEAR 5'h10
`define STC_ADDR_IRQ_ENABLE 5'h14
`define STC_ADDR_PORT 5'h18
`define STC_ADDR_SYSOSC 5'h1c
// control field positions
`define STC_CTL_ON 0
`define STC_CTL_CS 1
`define STC_CTL_SYNCDIS 2
`define STC_CTL_OSCEN 3
`define STC_CTL_PS_LO 4
`define STC_CTL_PS_HI 5
`define STC_CTL_RESET 8'h00
// system oscillator modes that allow the crystal as counter clock
`define STC_SYSOSC_LP 3'h0
`define STC_SYSOSC_INTIO 3'h4
// crystal oscillator nominal rate in hz
`define STC_XTAL_HZ 32768
`endif

// >>> logic/stc_pkg.sv
package stc_pkg;
  // edge arming state of counting mode
  typedef enum logic [1:0] {
    STC_ARM_WAIT_LOW,
    STC_ARM_READY,
    STC_ARM_IDLE
  } stc_arm_t;
endpackage

// >>> logic/stc_prescale.sv
`timescale 1ns/10ps
`default_nettype none
// prescaler: divides increment requests by 1, 2, 4 or 8
module stc_prescale (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] ratio,
  output logic tick_out
);
  // hidden prescale count, never visible to software
  typedef struct packed {
    logic [2:0] cnt_r;
  } stc_ps_state_t;
  stc_ps_state_t st_r;
  stc_ps_state_t st_nxt;
  logic [2:0] mask;

  // [RL15] code to ratio
  // mask of count bits that must all be one to pass a tick
  always_comb begin
    case (ratio)
      2'h3: mask = 3'h7; // divide by 8
      2'h2: mask = 3'h3; // divide by 4
      2'h1: mask = 3'h1; // divide by 2
      default: mask = 3'h0; // divide by 1
    endcase
  end

  assign tick_out = tick_in && !clear && ((st_r.cnt_r & mask) == mask);

  // next count, cleared on any counter write
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.cnt_r = 3'h0;
    end else if (tick_in) begin
      st_nxt.cnt_r = tick_out ? 3'h0 : 3'(st_r.cnt_r + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> logic/stc_timer.sv
// Overview of operation
// [RL1] 16-bit up counter, byte writes load directly
// [RL2] clock source bit picks fosc/4 or external
// [RL3] internal rate is fosc/4 over prescale
// [RL4] external mode counts external pin rising edges
// [RL5] rising edge needs prior falling edge seen
// [RL6] prescaler divides by 1, 2, 4, 8
// [RL7] prescaler hidden, cleared on counter byte write
// [RL8] oscillator enable starts crystal, runs in sleep
// [RL9] crystal only allowed in lp or intosc modes
// [RL10] crystal forces shared pins input, reads fixed
// [RL11] software waits crystal start-up before enabling
// [RL12] sync disable counts without phase synchronisation
// [RL13] async external counting runs in sleep, wakes
// [RL14] sync mode switches may lose or add one
// [RL15] prescale code 11=8, 10=4, 01=2, 00=1
// [RL16] rollover ffff to 0000 sets flag
// [RL17] cleared on bit freezes counter value
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "stc_defs.svh"
module stc_timer (
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // chip context
  input wire logic sleep_mode,
  input wire logic [2:0] sys_osc_mode,
  input wire logic external_clock_pin,
  input wire logic low_power_crystal_clock,
  input wire logic [1:0] port_dir_in,
  input wire logic [1:0] port_data_in,
  // outputs
  output logic crystal_osc_run,
  output logic [1:0] port_force_input,
  output logic irq,
  output logic wake
);
  // all state of the block except the prescale count, which lives in u_ps
  typedef struct packed {
    logic [15:0] count_r;
    logic [7:0] ctl_r;
    logic rollover_flag_r;
    logic irq_en_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic [1:0] pin_meta_r;
    logic [1:0] pin_sync_r;
    logic [1:0] xtal_meta_r;
    logic [1:0] xtal_sync_r;
    logic prev_src_r;
    stc_pkg::stc_arm_t arm_r;
  } stc_state_t;
  stc_state_t st_r;
  stc_state_t st_nxt;

  logic timer_on; // control bit decodes
  logic clock_source_select;
  logic sync_disable;
  logic crystal_osc_enable;
  logic [1:0] prescale_select;
  logic xtal_ok; // crystal legal in this oscillator mode
  logic src_level; // selected external level
  logic src_rise; // qualified rising edge
  logic src_now; // level on the tap in use
  logic src_fall; // falling edge on that tap
  logic raw_tick; // increment request before prescaler
  logic ps_tick; // increment after prescaler
  logic cnt_write; // either counter byte written
  logic wr_acc; // write accepted
  logic rd_acc; // read accepted
  logic [31:0] rd_mux; // read value

  // address compare used only by the counter write decode, the read mux uses a case
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  assign timer_on = st_r.ctl_r[`STC_CTL_ON];
  assign clock_source_select = st_r.ctl_r[`STC_CTL_CS];
  assign sync_disable = st_r.ctl_r[`STC_CTL_SYNCDIS];
  assign crystal_osc_enable = st_r.ctl_r[`STC_CTL_OSCEN];
  assign prescale_select = st_r.ctl_r[`STC_CTL_PS_HI:`STC_CTL_PS_LO];

  // [RL9] crystal gated by mode
  assign xtal_ok = crystal_osc_enable &&
    (sys_osc_mode == `STC_SYSOSC_LP || sys_osc_mode == `STC_SYSOSC_INTIO);
  // [RL8] crystal start output
  assign crystal_osc_run = xtal_ok;
  // [RL10] shared pins forced input
  assign port_force_input = {2{xtal_ok}};

  // external source level, from second synchroniser stage only
  assign src_level = xtal_ok ? st_r.xtal_sync_r[1] : st_r.pin_sync_r[1];
  // [RL12] sync disable uses earlier tap
  // async path always samples the pin, one stage earlier than the synchronised pin path, so a
  // mode change can drop or repeat one edge
  // [RL14] one step may slip
  // note: single clock design, both taps are already double-flopped
  assign src_now = sync_disable ? st_r.pin_sync_r[0] : src_level;
  // only a fall seen while on arms, a low level alone does not
  assign src_fall = !src_now && st_r.prev_src_r;
  assign src_rise = sync_disable ?
    (st_r.pin_sync_r[0] && !st_r.prev_src_r) :
    (src_level && !st_r.prev_src_r);

  // [RL2] clock source mux
  // [RL3] internal tick each cycle
  // [RL13] sleep halts only sync ticks
  always_comb begin
    if (!clock_source_select) begin
      raw_tick = !sleep_mode; // clk stands for fosc/4
    end else begin
      // [RL4] external rising edge
      raw_tick = src_rise && st_r.arm_r == stc_pkg::STC_ARM_READY &&
                 (sync_disable || !sleep_mode);
    end
  end

  assign wr_acc = avs_write;
  assign rd_acc = avs_read;
  // accepted write only, not the answer cycle of the same request
  assign cnt_write = wr_acc && !st_r.ack_r && avs_byteenable[0] &&
    (hit(avs_address, 5'(`STC_ADDR_COUNT_LOW)) ||
     hit(avs_address, 5'(`STC_ADDR_COUNT_HIGH)));

  // [RL6] prescaler instance
  // [RL7] cleared on counter write
  stc_prescale u_ps (
    .clk(clk),
    .resetn(resetn),
    .tick_in(raw_tick && timer_on),
    .clear(cnt_write),
    .ratio(prescale_select),
    .tick_out(ps_tick)
  );

  // read mux, reserved bits zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      5'(`STC_ADDR_COUNT_LOW): rd_mux[7:0] = st_r.count_r[7:0];
      5'(`STC_ADDR_COUNT_HIGH): rd_mux[7:0] = st_r.count_r[15:8];
      5'(`STC_ADDR_CONTROL): rd_mux[7:0] = st_r.ctl_r;
      5'(`STC_ADDR_STATUS): rd_mux[0] = st_r.rollover_flag_r;
      `STC_ADDR_IRQ_ENABLE: rd_mux[0] = st_r.irq_en_r;
      // [RL10] dir reads 1, data reads 0
      `STC_ADDR_PORT: begin
        rd_mux[1:0] = xtal_ok ? 2'h0 : port_data_in;
        rd_mux[9:8] = xtal_ok ? 2'h3 : port_dir_in;
      end
      `STC_ADDR_SYSOSC: rd_mux[2:0] = sys_osc_mode;
      default: rd_mux = 32'h0;
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_r = 1'b0;
    // four flops on each outside level, two meta then two sync
    st_nxt.pin_meta_r = {st_r.pin_meta_r[0], external_clock_pin};
    st_nxt.pin_sync_r = {st_r.pin_sync_r[0], st_r.pin_meta_r[1]};
    st_nxt.xtal_meta_r = {st_r.xtal_meta_r[0], low_power_crystal_clock};
    st_nxt.xtal_sync_r = {st_r.xtal_sync_r[0], st_r.xtal_meta_r[1]};
    st_nxt.prev_src_r = src_now;
    // [RL5] arm only after low seen
    case (st_r.arm_r)
      stc_pkg::STC_ARM_WAIT_LOW: begin
        // enabling with the pin already low still needs a fall
        if (timer_on && src_fall) begin
          st_nxt.arm_r = stc_pkg::STC_ARM_READY;
        end
      end
      stc_pkg::STC_ARM_READY: begin
        // [RL5] disable rearms
        if (!timer_on) begin
          st_nxt.arm_r = stc_pkg::STC_ARM_WAIT_LOW;
        end
      end
      default: st_nxt.arm_r = stc_pkg::STC_ARM_WAIT_LOW;
    endcase
    // [RL17] hold while off
    // [RL16] wrap and flag
    if (ps_tick) begin
      st_nxt.count_r = 16'(st_r.count_r + 16'h1);
      if (st_r.count_r == 16'hffff) begin
        st_nxt.rollover_flag_r = 1'b1;
      end
    end
    if (rd_acc && !st_r.ack_r) begin
      st_nxt.rdata_r = rd_mux;
      st_nxt.ack_r = 1'b1;
    end
    if (wr_acc && !st_r.ack_r) begin
      st_nxt.ack_r = 1'b1;
      if (avs_byteenable[0]) begin
        case (avs_address)
          // [RL1] direct byte load
          5'(`STC_ADDR_COUNT_LOW): begin
            st_nxt.count_r[7:0] = avs_writedata[7:0];
            st_nxt.arm_r = stc_pkg::STC_ARM_WAIT_LOW;
          end
          5'(`STC_ADDR_COUNT_HIGH): begin
            st_nxt.count_r[15:8] = avs_writedata[7:0];
            st_nxt.arm_r = stc_pkg::STC_ARM_WAIT_LOW;
          end
          5'(`STC_ADDR_CONTROL): st_nxt.ctl_r = avs_writedata[7:0];
          // hardware set wins over software clear
          `STC_ADDR_IRQ_CLEAR: begin
            if (avs_writedata[0] && !(ps_tick && st_r.count_r == 16'hffff))
            begin
              st_nxt.rollover_flag_r = 1'b0;
            end
          end
          `STC_ADDR_IRQ_ENABLE: st_nxt.irq_en_r = avs_writedata[0];
          default: st_nxt.ack_r = 1'b1; // unmapped or read-only: ignored
        endcase
      end
    end
  end

  // one cycle wait, then answer
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack_r;
  assign avs_readdata = st_r.rdata_r;
  // [RL13] rollover interrupt and wake
  assign irq = st_r.rollover_flag_r && st_r.irq_en_r;
  assign wake = irq && sleep_mode;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.ctl_r <= `STC_CTL_RESET;
      st_r.arm_r <= stc_pkg::STC_ARM_WAIT_LOW;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> tb/stc_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the timer
module stc_timer_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sleep_mode,
  input wire logic [2:0] sys_osc_mode,
  input wire logic crystal_osc_run,
  input wire logic [1:0] port_force_input,
  input wire logic irq,
  input wire logic wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a request appearing
  sequence req_up;
    $rose(avs_read || avs_write);
  endsequence
  // a read of the port view completing
  sequence port_rd;
    avs_read && !avs_waitrequest && avs_address == 5'h18;
  endsequence
  ans_one_a: assert property (req_up |=> !avs_waitrequest)
    else $error("answer late");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  force_pin_a: assert property (port_force_input == {2{crystal_osc_run}})
    else $error("pin force wrong");
  view_fix_a: assert property (port_rd ##0 crystal_osc_run |->
    avs_readdata[9:8] == 2'h3 && avs_readdata[1:0] == 2'h0)
    else $error("port view not fixed");
  xtal_mode_a: assert property (crystal_osc_run |->
    sys_osc_mode inside {3'h0, 3'h4})
    else $error("crystal in bad mode");
  xtal_start_a: assert property ($rose(crystal_osc_run) |-> $past(avs_write))
    else $error("crystal started alone");
  wake_irq_a: assert property (wake == (irq && sleep_mode))
    else $error("wake wrong");
  irq_drop_a: assert property ($fell(irq) |-> $past(avs_write))
    else $error("irq dropped alone");
endmodule
`default_nettype wire

// >>> tb/stc_ext_src.sv
`timescale 1ns/10ps
`default_nettype none
// far side: pin driver at rest level, free crystal
module stc_ext_src (
  input wire logic clk,
  input wire logic run,
  input wire logic lvl,
  input wire logic [3:0] half,
  output logic external_clock_pin,
  output logic low_power_crystal_clock
);
  logic [3:0] n = 4'h0;
  logic [1:0] x = 2'h0;
  initial external_clock_pin = 1'h0;
  initial low_power_crystal_clock = 1'h0;
  // pin toggles every half cycles in a burst
  always @(posedge clk) begin
    n <= (n >= half - 4'h1 || !run) ? 4'h0 : n + 4'h1;
    if (!run) external_clock_pin <= lvl;
    else if (n >= half - 4'h1) external_clock_pin <= !external_clock_pin;
    x <= (x == 2'h2) ? 2'h0 : x + 2'h1;
    if (x == 2'h2) low_power_crystal_clock <= !low_power_crystal_clock;
  end
endmodule
`default_nettype wire

// >>> tb/stc_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module stc_timer_bench;
  logic clk = '0, resetn = '0, avs_read = '0, avs_write = '0;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf, half = 4'h2;
  logic avs_waitrequest, sleep_mode = '0, run = '0, lvl = '0;
  logic external_clock_pin, low_power_crystal_clock;
  logic [2:0] sys_osc_mode = '0;
  logic [1:0] port_dir_in = '0, port_data_in = '0, port_force_input;
  logic crystal_osc_run, irq, wake;
  int fail_count = 0, cmp_count = 0, seed = 32591, rises, k, r;
  stc_timer dut (.*);
  stc_ext_src far (.*);
  always #50 clk = ~clk;
  // rises seen on the pin
  always @(posedge external_clock_pin) rises++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // rates allow two counts of edge slack
  task near(input logic [31:0] got, input int exp);
    cmp_count++;
    if ($isunknown(got) || got > exp + 2 || got + 2 < exp) begin
      fail_count++;
      $display("ERROR %0t rate %0d want %0d", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest low
  task bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(negedge clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    @(posedge clk);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task results;
    $display("%0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    r = $random(seed);
    port_dir_in <= r[1:0];
    port_data_in <= r[3:2];
    bus(1'h0, 5'h08, '0);
    chk(q, '0);
    // random loads into a stopped counter
    repeat (4) begin
      r = $random(seed);
      bus(1'h1, 5'h00, r[7:0]);
      bus(1'h1, 5'h04, r[15:8]);
      bus(1'h0, 5'h00, '0);
      chk(q, r[7:0]);
      bus(1'h0, 5'h04, '0);
      chk(q, r[15:8]);
    end
    bus(1'h0, 5'h01, '0);
    chk(q, '0);
    $display("load test done");
    // about 67 enabled cycles per ratio
    for (k = 0; k < 4; k++) begin
      bus(1'h1, 5'h00, '0);
      bus(1'h1, 5'h04, '0);
      bus(1'h1, 5'h08, 32'h1 | k << 4);
      repeat (64) @(posedge clk);
      bus(1'h1, 5'h08, '0);
      bus(1'h0, 5'h00, '0);
      near(q, 67 >> k);
    end
    $display("rate test done");
    bus(1'h1, 5'h00, 32'hfe);
    bus(1'h1, 5'h04, 32'hff);
    bus(1'h1, 5'h08, 32'h1);
    repeat (4) @(posedge clk);
    bus(1'h1, 5'h08, '0);
    bus(1'h0, 5'h0c, '0);
    chk(q, 32'h1);
    chk(irq, 1'h0);
    bus(1'h0, 5'h04, '0);
    chk(q, '0);
    bus(1'h1, 5'h14, 32'h1);
    sleep_mode <= 1'h1;
    @(negedge clk);
    chk({irq, wake}, 2'h3);
    bus(1'h1, 5'h10, 32'h1);
    @(negedge clk);
    chk(irq, 1'h0);
    sleep_mode <= 1'h0;
    $display("rollover test done");
    // pin low at enable, then high and async in sleep
    for (k = 0; k < 2; k++) begin
      lvl <= k[0];
      half <= k ? 4'h7 : 4'h2;
      bus(1'h1, 5'h08, '0);
      bus(1'h1, 5'h00, 32'hf8);
      bus(1'h1, 5'h04, 32'hff);
      bus(1'h1, 5'h08, k ? 32'h7 : 32'h3);
      sleep_mode <= k[0];
      rises = 0;
      run <= 1'h1;
      repeat (150) @(posedge clk);
      run <= 1'h0;
      lvl <= 1'h0;
      repeat (8) @(posedge clk);
      chk({irq, wake}, {1'h1, k[0]});
      sleep_mode <= 1'h0;
      bus(1'h0, 5'h00, '0);
      chk(q, (32'hf8 + rises - 1 + k) & 32'hff);
      bus(1'h1, 5'h10, 32'h1);
    end
    $display("pulse test done");
    for (k = 0; k < 8; k++) begin
      sys_osc_mode <= k[2:0];
      bus(1'h1, 5'h08, 32'h8); // crystal on, timer still off
      @(negedge clk);
      r = k == 0 || k == 4;
      chk(crystal_osc_run, r);
      bus(1'h0, 5'h18, '0);
      chk(q, r ? 32'h300 : {port_dir_in, 6'h0, port_data_in});
      bus(1'h1, 5'h08, '0);
    end
    $display("crystal test done");
    results;
  end
endmodule
bind stc_timer stc_timer_checker watch (.*);
`default_nettype wire
